// [pkg/trib_status_consts.svh]
// Offsets, field positions, reset values and timing counts of the tributary status logic
`ifndef TRIB_STATUS_CONSTS_SVH
`define TRIB_STATUS_CONSTS_SVH
`define N_PORT         8
`define N_SUPPLY       4
`define N_FPGA         2
`define N_EVT          5
`define TMO_W          17
`define CLK_MHZ        100
`define CFG_TIMEOUT_US 1000
`define A_CTRL         8'h00
`define A_PROV         8'h04
`define A_STATUS       8'h08
`define A_QUAL         8'h0c
`define A_FL_ADDR      8'h10
`define A_FL_DATA      8'h14
`define A_IRQ_STAT     8'h18
`define A_IRQ_CLR      8'h1c
`define A_IRQ_EN       8'h20
`define CTRL_ACTIVE    0
`define CTRL_START     1
`define CTRL_NEWBANK   2
`define QUAL_TYPE_LSB  8
`define QUAL_EVAL_LSB  16
`define ST_STATE_LSB   16
`define ST_BANK        18
`define ST_REVERTED    19
`define ST_CFG_ALARM   20
`define ST_MF          21
`define ST_FL_BUSY     22
`define EV_SUPPLY      0
`define EV_CFG_FAIL    1
`define EV_REVERT      2
`define EV_UNQUAL      3
`define EV_HOTPLUG     4
`define RST_NEWBANK    1'b0
`define RST_MF         1'b1
`endif

// [pkg/trib_status_pkg.sv]
// Types shared by the tributary status logic
`default_nettype none
`include "trib_status_consts.svh"
package trib_status_pkg;

  typedef enum logic [1:0] {
    CS_START = 2'b00,
    CS_WAIT  = 2'b01,
    CS_RUN   = 2'b11,
    CS_FAIL  = 2'b10
  } cfg_state_t;

  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic                  active;
    logic                  new_bank;
    logic [`N_PORT-1:0]    prov;
    logic [`N_PORT-1:0]    approved;
    logic [`N_PORT-1:0]    typeok;
    logic [`N_PORT-1:0]    evald;
    logic [`N_PORT-1:0]    present_q;
    logic [`N_PORT-1:0]    unq;
    logic [`N_PORT-1:0]    txdis;
    cfg_state_t            cfg_state;
    logic                  bank;
    logic                  reverted;
    logic                  cfg_alarm;
    logic                  cfg_start;
    logic [`TMO_W-1:0]     tmo;
    logic [23:0]           fl_addr;
    logic [31:0]           fl_data;
    logic                  fl_wr;
    logic [`N_EVT-1:0]     sticky;
    logic [`N_EVT-1:0]     irq_en;
    logic                  irq;
    logic                  mf;
    logic                  act;
    logic                  sf;
    logic                  sg;
    logic                  sy;
  } state_t;

endpackage
`default_nettype wire

// [core/trib_status.sv]
// Front-panel indicators, optic qualification and FPGA configuration sequencing of the tributary card
//
// Notes on behaviour
// (R01) Failure indicator red on any card failure
// (R02) Active indicator green while card active
// (R03) Signal-fail yellow when provisioned port alarms
// (R04) Presence green when all provisioned ports lit
// (R05) No provisioning: green if any port lit
// (R06) Presence yellow when provisioned port dark
// (R07) Presence off: nothing provisioned, nothing lit
// (R08) One presence indicator for all ports
// (R09) Load FPGAs automatically after reset
// (R10) Two flash banks, revert on bad image
// (R11) Controller may reload; alarm on failure
// (R12) Flash rewritable through software download
// (R13) Right type, unapproved: in service, alarm
// (R14) Wrong type, unapproved: disabled, alarm
// (R15) Hot plug re-evaluates each port
// (R16) Eight ports, STM-1 rate only
// (R17) Supply out of limits means module failure
// (R18) Indicators registered, safe during reset
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`default_nettype none
`include "trib_status_consts.svh"

module trib_status
  import trib_status_pkg::*;
#(
  parameter int CFG_TMO_CYC = `CFG_TIMEOUT_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Avalon-MM register slave
  input  wire logic [7:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  output var  logic [31:0]          readdata,
  output var  logic                 waitrequest,
  // Pluggable optics
  input  wire logic [`N_PORT-1:0]   sfp_present,
  input  wire logic [`N_PORT-1:0]   sfp_los,
  input  wire logic [`N_PORT-1:0]   port_alarm,
  output var  logic [`N_PORT-1:0]   sfp_tx_disable,
  // Supply monitors
  input  wire logic [`N_SUPPLY-1:0] supply_good,
  // FPGA configuration chain
  output var  logic                 cfg_start,
  output var  logic                 cfg_bank,
  input  wire logic                 cfg_done,
  input  wire logic [`N_FPGA-1:0]   cfg_ok,
  // Flash programming
  output var  logic                 flash_wr,
  output var  logic [23:0]          flash_addr,
  output var  logic [31:0]          flash_data,
  input  wire logic                 flash_busy,
  // Indicators and interrupt
  output var  logic                 module_failure_led,
  output var  logic                 active_state_led,
  output var  logic                 signal_fail_led,
  output var  logic                 optical_presence_led_green,
  output var  logic                 optical_presence_led_yellow,
  output var  logic                 irq
);

  localparam logic [`TMO_W-1:0] TMO_LIM = CFG_TMO_CYC[`TMO_W-1:0];

  state_t                st;
  state_t                n;
  logic                  bus_wr;
  logic                  bus_rd;
  logic                  trig;
  logic                  fault;
  logic                  miss;
  logic [`N_PORT-1:0]    sig;
  logic [`N_PORT-1:0]    chg;
  logic [`N_EVT-1:0]     ev;
  logic [`N_EVT-1:0]     clr;
  logic [31:0]           rd;
  logic                  qual_wr;
  logic [`N_PORT-1:0]    wrong_opt;
  logic [`N_PORT-1:0]    right_opt;

  // A request is answered one cycle after it is seen
  assign waitrequest = (read | write) & ~st.ack;
  assign bus_wr      = write & st.ack;
  assign bus_rd      = read & ~st.ack;
  assign trig        = bus_wr && address == `A_CTRL && writedata[`CTRL_START];
  assign fault       = ~&supply_good;
  assign sig         = sfp_present & ~sfp_los;
  assign chg         = sfp_present ^ st.present_q;
  assign miss        = |(st.prov & ~sig);
  assign qual_wr     = bus_wr && address == `A_QUAL;
  // Unapproved optics whose ruling no hot plug voids this cycle, split by type
  assign wrong_opt   = st.evald & sfp_present & st.present_q & ~st.approved & ~st.typeok;
  assign right_opt   = st.evald & sfp_present & st.present_q & ~st.approved & st.typeok;

  always_comb begin
    rd = '0;
    case (address)
      `A_CTRL: begin
        rd[`CTRL_ACTIVE]  = st.active;
        rd[`CTRL_NEWBANK] = st.new_bank;
      end
      `A_PROV: begin
        rd[`N_PORT-1:0] = st.prov;
      end
      `A_STATUS: begin
        rd[`N_PORT-1:0]            = st.unq;
        rd[`N_PORT+:`N_PORT]       = st.txdis;
        rd[`ST_STATE_LSB+:2]       = st.cfg_state;
        rd[`ST_BANK]               = st.bank;
        rd[`ST_REVERTED]           = st.reverted;
        rd[`ST_CFG_ALARM]          = st.cfg_alarm;
        rd[`ST_MF]                 = st.mf;
        rd[`ST_FL_BUSY]            = flash_busy;
      end
      `A_QUAL: begin
        rd[`N_PORT-1:0]            = st.approved;
        rd[`QUAL_TYPE_LSB+:`N_PORT] = st.typeok;
        rd[`QUAL_EVAL_LSB+:`N_PORT] = st.evald;
      end
      `A_FL_ADDR: begin
        rd[23:0] = st.fl_addr;
      end
      `A_IRQ_STAT: begin
        rd[`N_EVT-1:0] = st.sticky;
      end
      `A_IRQ_EN: begin
        rd[`N_EVT-1:0] = st.irq_en;
      end
      default: begin
        rd = '0;
      end
    endcase
  end

  always_comb begin
    n           = st;
    ev          = '0;
    clr         = '0;
    n.ack       = (read | write) & ~st.ack;
    n.cfg_start = 1'b0;
    n.fl_wr     = 1'b0;
    if (bus_rd) begin
      n.rdata = rd;
    end
    if (bus_wr) begin
      case (address)
        `A_CTRL: begin
          n.active   = writedata[`CTRL_ACTIVE];
          n.new_bank = writedata[`CTRL_NEWBANK]; // [R10]
        end
        `A_PROV: begin
          n.prov = writedata[`N_PORT-1:0];
        end
        `A_QUAL: begin
          // Software rules on each present optic after reading its identity
          n.approved = writedata[`N_PORT-1:0];
          n.typeok   = writedata[`QUAL_TYPE_LSB+:`N_PORT];
          n.evald    = sfp_present;
        end
        `A_FL_ADDR: begin
          n.fl_addr = writedata[23:0]; // [R12]
        end
        `A_FL_DATA: begin
          // A word written while the flash is busy is dropped
          if (!flash_busy) begin
            n.fl_data = writedata; // [R12]
            n.fl_wr   = 1'b1;
          end
        end
        `A_IRQ_CLR: begin
          clr = writedata[`N_EVT-1:0];
        end
        `A_IRQ_EN: begin
          n.irq_en = writedata[`N_EVT-1:0];
        end
        default: begin
          n.irq_en = st.irq_en;
        end
      endcase
    end

    // Insertion or removal voids the earlier ruling; wins over a software write
    n.present_q = sfp_present;
    n.evald     = n.evald & ~chg; // [R15]
    n.approved  = n.approved & ~chg; // [R15]
    n.typeok    = n.typeok & ~chg; // [R15]
    ev[`EV_HOTPLUG] = |chg;
    // Unruled optics go dark the cycle after they appear; sfp_tx_disable is low in reset and in that first cycle, so any part can light the fibre
    n.txdis = sfp_present & ~(n.evald & (n.approved | n.typeok)); // [R13] [R14] [R16]
    n.unq   = n.evald & sfp_present & ~n.approved; // [R13] [R14]
    ev[`EV_UNQUAL] = |(n.unq & ~st.unq);

    case (st.cfg_state)
      CS_START: begin
        n.cfg_start = 1'b1; // [R09]
        n.tmo       = '0;
        n.cfg_state = CS_WAIT;
      end
      CS_WAIT: begin
        n.tmo = st.tmo + 1'b1;
        if (cfg_done && (&cfg_ok)) begin
          n.cfg_state = CS_RUN;
          n.cfg_alarm = 1'b0;
        end else if (cfg_done || st.tmo == TMO_LIM) begin
          if (!st.reverted) begin
            n.reverted  = 1'b1; // [R10]
            n.bank      = ~st.bank; // [R10]
            n.cfg_state = CS_START;
            ev[`EV_REVERT] = 1'b1;
          end else begin
            n.cfg_state = CS_FAIL;
            n.cfg_alarm = 1'b1; // [R11]
            ev[`EV_CFG_FAIL] = 1'b1;
          end
        end
      end
      CS_RUN, CS_FAIL: begin
        // A reload request during loading is ignored
        if (trig) begin
          n.cfg_state = CS_START; // [R11]
          n.bank      = n.new_bank;
          n.reverted  = 1'b0;
        end
      end
      default: begin
        n.cfg_state = CS_FAIL;
      end
    endcase

    ev[`EV_SUPPLY] = fault;
    n.sticky = (st.sticky & ~clr) | ev;
    n.irq    = |(n.sticky & n.irq_en);

    n.mf  = fault | (st.cfg_state == CS_FAIL); // [R01] [R17]
    n.act = st.active; // [R02]
    n.sf  = |(st.prov & port_alarm); // [R03]
    // One indicator summarises every port
    n.sy  = miss; // [R06] [R08]
    n.sg  = (|st.prov) ? ~miss : (|sig); // [R04] [R05] [R07]
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st          <= '0; // [R18]
      st.mf       <= `RST_MF; // [R18]
      st.new_bank <= `RST_NEWBANK;
      st.bank     <= `RST_NEWBANK;
    end else begin
      st <= n;
    end
  end

  assign readdata                    = st.rdata;
  assign sfp_tx_disable              = st.txdis;
  assign cfg_start                   = st.cfg_start;
  assign cfg_bank                    = st.bank;
  assign flash_wr                    = st.fl_wr;
  assign flash_addr                  = st.fl_addr;
  assign flash_data                  = st.fl_data;
  assign module_failure_led          = st.mf;
  assign active_state_led            = st.act;
  assign signal_fail_led             = st.sf;
  assign optical_presence_led_green  = st.sg;
  assign optical_presence_led_yellow = st.sy;
  assign irq                         = st.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_supply_mf; // [R17]
    fault |=> module_failure_led;
  endproperty
  a_supply_mf: assert property (p_supply_mf) else $error("supply fault did not light failure");

  property p_mf_dark; // [R01]
    (!fault && st.cfg_state == CS_RUN) |=> !module_failure_led;
  endproperty
  a_mf_dark: assert property (p_mf_dark) else $error("failure lit without cause");

  property p_act; // [R02]
    st.active |=> active_state_led;
  endproperty
  a_act: assert property (p_act) else $error("active indicator not lit");

  property p_sf; // [R03]
    (|(st.prov & port_alarm)) |=> signal_fail_led;
  endproperty
  a_sf: assert property (p_sf) else $error("signal fail not lit");

  property p_all_lit; // [R04]
    ((|st.prov) && !miss) |=> optical_presence_led_green && !optical_presence_led_yellow;
  endproperty
  a_all_lit: assert property (p_all_lit) else $error("presence not green");

  property p_unprov_lit; // [R05]
    (st.prov == '0 && sig != '0) |=> optical_presence_led_green;
  endproperty
  a_unprov_lit: assert property (p_unprov_lit) else $error("unprovisioned light not shown");

  property p_missing; // [R06]
    miss |=> optical_presence_led_yellow && !optical_presence_led_green;
  endproperty
  a_missing: assert property (p_missing) else $error("missing light not yellow");

  property p_dark; // [R07]
    (st.prov == '0 && sig == '0) |=> !optical_presence_led_green && !optical_presence_led_yellow;
  endproperty
  a_dark: assert property (p_dark) else $error("presence not off");

  property p_revert; // [R10]
    (st.cfg_state == CS_WAIT && cfg_done && !(&cfg_ok) && !st.reverted)
      |=> st.reverted && cfg_bank != $past(cfg_bank) ##1 cfg_start;
  endproperty
  a_revert: assert property (p_revert) else $error("no reload from other bank");

  property p_cfg_alarm; // [R11]
    (st.cfg_state == CS_WAIT && cfg_done && !(&cfg_ok) && st.reverted)
      |=> st.cfg_alarm ##1 module_failure_led;
  endproperty
  a_cfg_alarm: assert property (p_cfg_alarm) else $error("failed load raised no alarm");

  property p_flash; // [R12]
    (write && !waitrequest && address == `A_FL_DATA && !flash_busy)
      |=> flash_wr && flash_data == $past(writedata) ##1 !flash_wr;
  endproperty
  a_flash: assert property (p_flash) else $error("flash word not issued once");

  property p_flash_drop; // [R12]
    (write && !waitrequest && address == `A_FL_DATA && flash_busy) |=> !flash_wr;
  endproperty
  a_flash_drop: assert property (p_flash_drop) else $error("word issued to a busy flash");

  property p_wrong_type; // [R14]
    (wrong_opt != '0 && !qual_wr)
      |=> (sfp_tx_disable & st.unq & $past(wrong_opt)) == $past(wrong_opt);
  endproperty
  a_wrong_type: assert property (p_wrong_type) else $error("wrong optic not disabled");

  property p_right_type; // [R13]
    (right_opt != '0 && !qual_wr)
      |=> (~sfp_tx_disable & st.unq & $past(right_opt)) == $past(right_opt);
  endproperty
  a_right_type: assert property (p_right_type) else $error("usable optic not kept");

  property p_hotplug; // [R15]
    (sfp_present[0] && !st.present_q[0]) |=> !st.evald[0] && sfp_tx_disable[0];
  endproperty
  a_hotplug: assert property (p_hotplug) else $error("insertion not re-evaluated");

  property p_hotplug_evt; // [R15]
    (sfp_present != st.present_q) |=> st.sticky[`EV_HOTPLUG];
  endproperty
  a_hotplug_evt: assert property (p_hotplug_evt) else $error("insertion raised no event");

  property p_tmo_revert; // [R10]
    (st.cfg_state == CS_WAIT && !cfg_done && st.tmo == TMO_LIM && !st.reverted)
      |=> st.reverted && st.cfg_state == CS_START;
  endproperty
  a_tmo_revert: assert property (p_tmo_revert) else $error("silent load did not switch bank");

  property p_reload; // [R11]
    (trig && (st.cfg_state == CS_RUN || st.cfg_state == CS_FAIL)) |=> ##1 cfg_start;
  endproperty
  a_reload: assert property (p_reload) else $error("reload request not started");

  property p_boot; // [R09]
    $fell(rst) |-> ##[1:2] cfg_start;
  endproperty
  a_boot: assert property (@(posedge clk_sys) p_boot) else $error("no load after reset");

endmodule // trib_status
`default_nettype wire

// [tb/trib_far_side.sv]
// Far-side model: FPGA configuration chain and flash device answering the status logic
`default_nettype none
`include "trib_status_consts.svh"

module trib_far_side (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Configuration chain
  input  wire logic               cfg_start,
  input  wire logic               cfg_bank,
  output var  logic               cfg_done,
  output var  logic [`N_FPGA-1:0] cfg_ok,
  // Flash device
  input  wire logic               flash_wr,
  output var  logic               flash_busy,
  // Scenario controls
  input  wire logic [1:0]         bad_bank,
  input  wire logic [3:0]         ans_dly
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;
  logic [2:0] busy_cnt;
  logic       tog;

  // Outside a done pulse the status lines toggle, so a stale sample never looks valid
  assign cfg_ok = cfg_done ? (bad_bank[cfg_bank] ? `N_FPGA'(1) : {`N_FPGA{1'b1}}) : `N_FPGA'({tog, ~tog});
  assign flash_busy = (busy_cnt != 3'h0);

  // A zero answer delay means the chain never answers at all
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt      <= 4'h0;
      cfg_done <= 1'b0;
      busy_cnt <= 3'h0;
      tog      <= 1'b0;
    end else begin
      tog      <= ~tog;
      cfg_done <= (cnt == 4'h1);
      if (cfg_start)
        cnt <= ans_dly;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      if (flash_wr)
        busy_cnt <= 3'h6;
      else if (busy_cnt != 3'h0)
        busy_cnt <= busy_cnt - 3'h1;
    end
  end
endmodule  // trib_far_side
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the tributary status logic
`default_nettype none
`include "trib_status_consts.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  sfp_present = 8'h00;
  logic [7:0]  sfp_los = 8'hff;
  logic [7:0]  port_alarm = 8'h00;
  logic [7:0]  sfp_tx_disable;
  logic [3:0]  supply_good = 4'hf;
  logic        cfg_start;
  logic        cfg_bank;
  logic        cfg_done;
  logic [1:0]  cfg_ok;
  logic        flash_wr;
  logic [23:0] flash_addr;
  logic [31:0] flash_data;
  logic        flash_busy;
  logic        module_failure_led;
  logic        active_state_led;
  logic        signal_fail_led;
  logic        optical_presence_led_green;
  logic        optical_presence_led_yellow;
  logic        irq;
  logic [1:0]  bad_bank = 2'b00;
  logic [3:0]  ans_dly = 4'h4;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          n_fwr = 0;
  int          n;
  logic [7:0]  tp [6] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'h03, 8'h81};
  logic [7:0]  tl [6] = '{8'h00, 8'h04, 8'h03, 8'h07, 8'h01, 8'h00};
  logic [1:0]  tg [6] = '{2'b00, 2'b10, 2'b10, 2'b10, 2'b01, 2'b01};

  always #5 clk_sys = ~clk_sys;

  // Short timeout keeps the configuration failure paths quick
  trib_status #(.CFG_TMO_CYC(50)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sfp_present(sfp_present), .sfp_los(sfp_los), .port_alarm(port_alarm),
    .sfp_tx_disable(sfp_tx_disable), .supply_good(supply_good), .cfg_start(cfg_start),
    .cfg_bank(cfg_bank), .cfg_done(cfg_done), .cfg_ok(cfg_ok), .flash_wr(flash_wr),
    .flash_addr(flash_addr), .flash_data(flash_data), .flash_busy(flash_busy),
    .module_failure_led(module_failure_led), .active_state_led(active_state_led),
    .signal_fail_led(signal_fail_led), .optical_presence_led_green(optical_presence_led_green),
    .optical_presence_led_yellow(optical_presence_led_yellow), .irq(irq));

  trib_far_side u_far (
    .clk_sys(clk_sys), .rst(rst), .cfg_start(cfg_start), .cfg_bank(cfg_bank), .cfg_done(cfg_done),
    .cfg_ok(cfg_ok), .flash_wr(flash_wr), .flash_busy(flash_busy), .bad_bank(bad_bank),
    .ans_dly(ans_dly));

  always @(posedge clk_sys) if (flash_wr === 1'b1) n_fwr <= n_fwr + 1;

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until waitrequest is seen low; the slave's latency is never assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_sys);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= ~wr;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0) begin
      n_mismatch++;
      close_out();
    end
    // Taken at the edge where waitrequest is seen low, released by the same edge
    r = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  // Polls until the load ends in run or in failure
  task automatic wait_cfg(output logic [31:0] s);
    int k;
    k = 0;
    do begin
      rd(`A_STATUS, s);
      k++;
    end while (s[`ST_STATE_LSB+1] !== 1'b1 && k < 40);
    if (k >= 40) begin
      n_mismatch++;
      close_out();
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("reset leds", {module_failure_led, active_state_led, signal_fail_led}, 32'h4);
    @(posedge clk_sys);
    rst <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (cfg_start !== 1'b1 && n < 10);
    chk("boot start", cfg_start, 1'b1);
    wait_cfg(q);
    chk("boot state", q[`ST_STATE_LSB+:2], 2'b11);
    chk("mf idle", module_failure_led, 1'b0);
    wr(`A_CTRL, 32'h1);
    settle();
    chk("active led", active_state_led, 1'b1);
    rd(8'h40, q);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      sfp_present <= tl[i];
      sfp_los     <= ~tl[i];
      wr(`A_PROV, {24'h0, tp[i]});
      settle();
      chk("presence", {optical_presence_led_green, optical_presence_led_yellow}, tg[i]);
    end
    wr(`A_PROV, 32'h3);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      port_alarm <= 8'h04 >> i;
      settle();
      chk("signal fail", signal_fail_led, i[0]);
    end
    // Supply fault: enabled interrupt, then masked, then cleared
    wr(`A_IRQ_CLR, 32'h1f);
    wr(`A_IRQ_EN, 32'h1);
    supply_good <= 4'hb;
    settle();
    chk("supply mf", {module_failure_led, irq}, 2'b11);
    wr(`A_IRQ_EN, 32'h0);
    settle();
    chk("masked irq", irq, 1'b0);
    @(posedge clk_sys);
    supply_good <= 4'hf;
    wr(`A_IRQ_EN, 32'h1);
    rd(`A_IRQ_STAT, q);
    chk("supply event", q[`EV_SUPPLY], 1'b1);
    wr(`A_IRQ_CLR, 32'h1);
    settle();
    chk("cleared", {module_failure_led, irq}, 2'b00);
    // Optic qualification on hot insertion
    @(posedge clk_sys);
    sfp_present <= 8'h00;
    settle();
    wr(`A_IRQ_CLR, 32'h1f);
    sfp_present <= 8'h03;
    settle();
    chk("unevaluated", sfp_tx_disable, 8'h03);
    wr(`A_QUAL, 32'h0100);
    settle();
    chk("qualified", sfp_tx_disable, 8'h02);
    rd(`A_STATUS, q);
    chk("unapproved alarm", q[0], 1'b1);
    rd(`A_IRQ_STAT, q);
    chk("optic events", {q[`EV_HOTPLUG], q[`EV_UNQUAL]}, 2'b11);
    sfp_present <= 8'h02;
    settle();
    @(posedge clk_sys);
    sfp_present <= 8'h03;
    settle();
    chk("reinserted", sfp_tx_disable, 8'h03);
    // Bad new bank reverts to the old one
    @(posedge clk_sys);
    bad_bank <= 2'b10;
    wr(`A_CTRL, 32'h7);
    settle();
    wait_cfg(q);
    chk("revert", {q[`ST_STATE_LSB+:2], q[`ST_BANK], q[`ST_REVERTED], cfg_bank}, 5'b11010);
    rd(`A_IRQ_STAT, q);
    chk("revert event", q[`EV_REVERT], 1'b1);
    // Both banks bad: the first load times out, the reload answers with a failure
    bad_bank <= 2'b11;
    ans_dly  <= 4'h0;
    wr(`A_CTRL, 32'h7);
    settle();
    @(posedge clk_sys);
    ans_dly <= 4'h4;
    wait_cfg(q);
    chk("cfg failed", {q[`ST_STATE_LSB+:2], q[`ST_CFG_ALARM], module_failure_led}, 4'b1011);
    rd(`A_IRQ_STAT, q);
    chk("cfg event", q[`EV_CFG_FAIL], 1'b1);
    // Flash download; the second word meets a busy flash and is dropped
    wr(`A_FL_ADDR, 32'h123456);
    wr(`A_FL_DATA, 32'hcafe0001);
    wr(`A_FL_DATA, 32'h0bad0bad);
    settle();
    chk("flash addr", flash_addr, 24'h123456);
    chk("flash data", flash_data, 32'hcafe0001);
    chk("flash writes", n_fwr, 1);
    close_out();
  end
endmodule  // tb_top
`default_nettype wire
